//--- include/mix_defs.vh
`ifndef MIX_DEFS_VH
`define MIX_DEFS_VH
// ==========================================================
// Register byte offsets
`define MIX_OFF_INSTR 8'h00
`define MIX_OFF_ACC 8'h04
`define MIX_OFF_STATUS 8'h08
`define MIX_OFF_PC 8'h0C
`define MIX_OFF_TPTR 8'h10
`define MIX_OFF_THI 8'h14
`define MIX_OFF_MADDR 8'h18
`define MIX_OFF_MDATA 8'h1C
`define MIX_OFF_CYCLES 8'h20
// ==========================================================
// Instruction word fields
`define MIX_F_OP_LSB 0
`define MIX_F_OP_MSB 4
`define MIX_F_BIT_LSB 5
`define MIX_F_BIT_MSB 7
`define MIX_F_ADR_LSB 8
`define MIX_F_ADR_MSB 15
`define MIX_F_IMM_LSB 16
`define MIX_F_IMM_MSB 23
// ==========================================================
// Status fields
`define MIX_ST_C 0
`define MIX_ST_HC 1
`define MIX_ST_Z 2
`define MIX_ST_SR 3
`define MIX_ST_PD 4
`define MIX_ST_WDT 5
`define MIX_ST_BUSY 8
`define MIX_ST_SKIP 9
// ==========================================================
// Operation codes
`define MIX_OP_SET 5'h00
`define MIX_OP_SETB 5'h01
`define MIX_OP_INCS 5'h02
`define MIX_OP_INCAS 5'h03
`define MIX_OP_SBIT1 5'h04
`define MIX_OP_SUB 5'h05
`define MIX_OP_SUBINTO 5'h06
`define MIX_OP_SUBI 5'h07
`define MIX_OP_SWAP 5'h08
`define MIX_OP_SWAPACC 5'h09
`define MIX_OP_SKZ 5'h0A
`define MIX_OP_CPSKZ 5'h0B
`define MIX_OP_SBIT0 5'h0C
`define MIX_OP_TRDC 5'h0D
`define MIX_OP_TRDL 5'h0E
`define MIX_OP_XOR 5'h0F
`define MIX_OP_XORINTO 5'h10
`define MIX_OP_XORI 5'h11
// ==========================================================
// Reset values and sizes
`define MIX_RST_BYTE 8'h00
`define MIX_RST_PC 12'h000
`define MIX_LAST_PAGE 4'hB
`define MIX_CYC_ONE 2'h1
`define MIX_CYC_TWO 2'h2
`endif

//--- rtl/mix_alu.v
`timescale 1ns/1ps
`include "mix_defs.vh"
// ==========================================================
// Combinational result, flag and skip unit
module mix_alu
(
  // Operands
  input wire [4:0] op,
  input wire [2:0] bsel,
  input wire [7:0] acc,
  input wire [7:0] mem,
  input wire [7:0] imm,
  input wire [3:0] flags_in,
  // Results
  output reg [7:0] res,
  output reg wr_acc,
  output reg wr_mem,
  output reg [3:0] flags_out,
  output reg skip
);
  reg [8:0] dif;
  reg [4:0] hdif;
  reg [7:0] sub_op;
  reg [7:0] inc;

  function [7:0] bit_mask;
    input [2:0] b;
    begin
      bit_mask = 8'h01 << b;
    end
  endfunction

  always @*
  begin
    res = mem;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    flags_out = flags_in;
    skip = 1'b0;
    inc = mem + 8'h01;
    sub_op = (op == `MIX_OP_SUBI) ? imm : mem;
    // RULE_06 complement add
    dif = {1'b0, acc} + {1'b0, ~sub_op} + 9'h001;
    hdif = {1'b0, acc[3:0]} + {1'b0, ~sub_op[3:0]} + 5'h01;
    case (op)
      // RULE_01 set all ones
      `MIX_OP_SET:
      begin
        res = 8'hFF;
        wr_mem = 1'b1;
      end
      // RULE_01 set one bit
      `MIX_OP_SETB:
      begin
        res = mem | bit_mask(bsel);
        wr_mem = 1'b1;
      end
      // RULE_02 increment and skip
      `MIX_OP_INCS:
      begin
        res = inc;
        wr_mem = 1'b1;
        skip = (inc == 8'h00);
      end
      // RULE_03 increment into acc
      `MIX_OP_INCAS:
      begin
        res = inc;
        wr_acc = 1'b1;
        skip = (inc == 8'h00);
      end
      // RULE_04 skip bit one
      `MIX_OP_SBIT1:
        skip = ((mem & bit_mask(bsel)) != 8'h00);
      // RULE_12 skip bit zero
      `MIX_OP_SBIT0:
        skip = ((mem & bit_mask(bsel)) == 8'h00);
      // RULE_06 RULE_07 RULE_08 subtract
      `MIX_OP_SUB, `MIX_OP_SUBINTO, `MIX_OP_SUBI:
      begin
        res = dif[7:0];
        wr_acc = (op != `MIX_OP_SUBINTO);
        wr_mem = (op == `MIX_OP_SUBINTO);
        flags_out[`MIX_ST_C] = dif[8];
        flags_out[`MIX_ST_HC] = hdif[4];
        flags_out[`MIX_ST_Z] = (dif[7:0] == 8'h00);
        flags_out[`MIX_ST_SR] = (acc[7] ^ sub_op[7]) & (acc[7] ^ dif[7]);
      end
      // RULE_09 nibble swap
      `MIX_OP_SWAP, `MIX_OP_SWAPACC:
      begin
        res = {mem[3:0], mem[7:4]};
        wr_mem = (op == `MIX_OP_SWAP);
        wr_acc = (op == `MIX_OP_SWAPACC);
      end
      // RULE_10 skip if zero
      `MIX_OP_SKZ:
        skip = (mem == 8'h00);
      // RULE_11 copy and skip
      `MIX_OP_CPSKZ:
      begin
        wr_acc = 1'b1;
        skip = (mem == 8'h00);
      end
      // RULE_15 RULE_16 RULE_17 exclusive or
      `MIX_OP_XOR, `MIX_OP_XORINTO, `MIX_OP_XORI:
      begin
        res = acc ^ ((op == `MIX_OP_XORI) ? imm : mem);
        wr_acc = (op != `MIX_OP_XORINTO);
        wr_mem = (op == `MIX_OP_XORINTO);
        flags_out[`MIX_ST_Z] = (res == 8'h00);
      end
      default:
        res = mem;
    endcase
  end
endmodule // mix_alu

//--- rtl/mix_dmem.v
`timescale 1ns/1ps
// ==========================================================
// Data memory, one write port, combinational read
module mix_dmem
(
  // Clock
  input wire clk,
  // Access
  input wire [7:0] addr,
  input wire we,
  input wire [7:0] wdata,
  output wire [7:0] rdata
);
  reg [7:0] mem_ff [0:255];

  // Contents are not cleared by reset, as in real RAM
  always @(posedge clk)
  begin
    if (we)
      mem_ff[addr] <= wdata;
  end

  assign rdata = mem_ff[addr];
endmodule // mix_dmem

//--- rtl/mix_core.v
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "mix_defs.vh"
// Functional notes
// RULE_01 - Set writes FFh to the byte, the bit form sets only the chosen bit, flags untouched.
// RULE_02 - Increment-and-skip writes byte plus one back and skips when it becomes zero.
// RULE_03 - Increment-to-acc puts byte plus one in acc, memory kept, skips on zero.
// RULE_04 - Skip-if-bit-one skips when the chosen bit is one, flags untouched.
// RULE_05 - A taken skip drops the next instruction and costs a dummy cycle, two in all.
// RULE_06 - Subtract puts acc plus inverted byte plus one in acc and updates all four math flags.
// RULE_07 - Subtract-to-memory stores the same difference into the byte with the same flags.
// RULE_08 - Subtract-immediate uses the opcode constant the same way as the memory form.
// RULE_09 - Swap exchanges the nibbles in place, the acc form writes acc only, no flags.
// RULE_10 - Skip-if-zero skips when the whole byte is zero and changes nothing.
// RULE_11 - Copy-and-skip loads the byte into acc and skips when it is zero.
// RULE_12 - Skip-if-bit-zero skips when the chosen bit is zero, else one cycle.
// RULE_13 - Current-page table read puts ROM low byte in memory and high byte in the latch.
// RULE_14 - Last-page table read does the same from the last program page.
// RULE_15 - Xor-memory puts acc xor byte into acc and touches only Z.
// RULE_16 - Xor-to-memory writes byte xor acc back into the byte, only Z changes.
// RULE_17 - Xor-immediate puts acc xor constant into acc and touches only Z.
module mix_core
(
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_ff,
  output reg pready_ff,
  output reg pslverr_ff,
  // Program ROM
  output reg [11:0] rom_addr_ff,
  output reg rom_rd_ff,
  input wire [15:0] rom_rdata,
  // Status
  output reg busy_ff
);
  // ==========================================================
  // States
  localparam S_IDLE = 2'd0;
  localparam S_EXEC = 2'd1;
  localparam S_DUMMY = 2'd2;
  localparam S_TBL = 2'd3;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [23:0] instr_ff;
  reg [7:0] acc_ff;
  reg [3:0] flags_ff;
  reg [11:0] pc_ff;
  reg [7:0] table_pointer_ff;
  reg [7:0] table_high_latch_ff;
  reg [7:0] maddr_ff;
  reg skip_ff;
  reg [1:0] cycles_ff;
  reg [31:0] nxt_prdata;
  reg nxt_err;

  wire [4:0] op;
  wire [2:0] bsel;
  wire [7:0] iadr;
  wire [7:0] imm;
  wire [7:0] mem_rdata;
  wire [7:0] alu_res;
  wire alu_wr_acc;
  wire alu_wr_mem;
  wire [3:0] alu_flags;
  wire alu_skip;
  wire acc_phase;
  wire wr_ok;
  wire exec_ok;
  wire tbl_op;
  wire mem_we;
  wire [7:0] mem_addr;
  wire [7:0] mem_wdata;

  assign op = instr_ff[`MIX_F_OP_MSB:`MIX_F_OP_LSB];
  assign bsel = instr_ff[`MIX_F_BIT_MSB:`MIX_F_BIT_LSB];
  assign iadr = instr_ff[`MIX_F_ADR_MSB:`MIX_F_ADR_LSB];
  assign imm = instr_ff[`MIX_F_IMM_MSB:`MIX_F_IMM_LSB];
  assign tbl_op = (op == `MIX_OP_TRDC) || (op == `MIX_OP_TRDL);

  // ==========================================================
  // Bus decode
  function is_reg;
    input [7:0] a;
    input [7:0] off;
    begin
      is_reg = (a == off);
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = is_reg(a, `MIX_OFF_INSTR) || is_reg(a, `MIX_OFF_ACC)
        || is_reg(a, `MIX_OFF_STATUS) || is_reg(a, `MIX_OFF_PC)
        || is_reg(a, `MIX_OFF_TPTR) || is_reg(a, `MIX_OFF_THI)
        || is_reg(a, `MIX_OFF_MADDR) || is_reg(a, `MIX_OFF_MDATA)
        || is_reg(a, `MIX_OFF_CYCLES);
    end
  endfunction

  // ==========================================================
  // Program counter step; a taken skip also steps over the dropped word
  function [11:0] pc_adv;
    input [11:0] p;
    input two;
    begin
      if (two)
        pc_adv = p + 12'h002;
      else
        pc_adv = p + 12'h001;
    end
  endfunction

  // ==========================================================
  // Status word built from the field positions, so the map lives in one place
  function [31:0] status_word;
    input [3:0] f;
    input bz;
    input sk;
    begin
      status_word = 32'h00000000;
      status_word[`MIX_ST_C] = f[`MIX_ST_C];
      status_word[`MIX_ST_HC] = f[`MIX_ST_HC];
      status_word[`MIX_ST_Z] = f[`MIX_ST_Z];
      status_word[`MIX_ST_SR] = f[`MIX_ST_SR];
      // No power-down or watchdog logic here, those bits read zero
      status_word[`MIX_ST_PD] = 1'b0;
      status_word[`MIX_ST_WDT] = 1'b0;
      status_word[`MIX_ST_BUSY] = bz;
      status_word[`MIX_ST_SKIP] = sk;
    end
  endfunction

  // Access phase is answered one cycle after it opens
  assign acc_phase = psel && penable && !pready_ff;
  // Writes during execution are refused so software never races the core
  assign wr_ok = acc_phase && pwrite && mapped(paddr) && !busy_ff;
  assign exec_ok = wr_ok && is_reg(paddr, `MIX_OFF_INSTR);

  // ==========================================================
  // Data memory port sharing
  assign mem_addr = busy_ff ? iadr : maddr_ff;
  assign mem_we = (state_ff == S_EXEC && alu_wr_mem && !tbl_op)
    || (state_ff == S_TBL)
    || (wr_ok && is_reg(paddr, `MIX_OFF_MDATA));
  // RULE_13 RULE_14 low byte to memory
  assign mem_wdata = (state_ff == S_TBL) ? rom_rdata[7:0]
    : (busy_ff ? alu_res : pwdata[7:0]);

  mix_dmem u_dmem
  (
    .clk(clk),
    .addr(mem_addr),
    .we(mem_we),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  mix_alu u_alu
  (
    .op(op),
    .bsel(bsel),
    .acc(acc_ff),
    .mem(mem_rdata),
    .imm(imm),
    .flags_in(flags_ff),
    .res(alu_res),
    .wr_acc(alu_wr_acc),
    .wr_mem(alu_wr_mem),
    .flags_out(alu_flags),
    .skip(alu_skip)
  );

  // ==========================================================
  // Sequencer
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE:
        if (exec_ok)
          nxt_state = S_EXEC;
      S_EXEC:
        if (tbl_op)
          nxt_state = S_TBL;
        // RULE_05 dummy cycle
        else if (alu_skip)
          nxt_state = S_DUMMY;
        else
          nxt_state = S_IDLE;
      S_DUMMY:
        nxt_state = S_IDLE;
      // Second table cycle carries the ROM word, it is not a dummy
      S_TBL:
        nxt_state = S_IDLE;
      default:
        nxt_state = S_IDLE;
    endcase
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_ff <= S_IDLE;
      busy_ff <= 1'b0;
      instr_ff <= 24'h000000;
      acc_ff <= `MIX_RST_BYTE;
      flags_ff <= 4'h0;
      pc_ff <= `MIX_RST_PC;
      skip_ff <= 1'b0;
      cycles_ff <= 2'h0;
      rom_addr_ff <= 12'h000;
      rom_rd_ff <= 1'b0;
      table_high_latch_ff <= `MIX_RST_BYTE;
    end
    else
    begin
      state_ff <= nxt_state;
      busy_ff <= (nxt_state != S_IDLE);
      rom_rd_ff <= 1'b0;
      if (exec_ok)
        instr_ff <= pwdata[23:0];
      if (state_ff == S_EXEC && tbl_op)
      begin
        rom_rd_ff <= 1'b1;
        // RULE_13 current page
        if (op == `MIX_OP_TRDC)
          rom_addr_ff <= {pc_ff[11:8], table_pointer_ff};
        // RULE_14 last page
        else
          rom_addr_ff <= {`MIX_LAST_PAGE, table_pointer_ff};
      end
      else if (state_ff == S_EXEC)
      begin
        if (alu_wr_acc)
          acc_ff <= alu_res;
        flags_ff <= alu_flags;
        skip_ff <= alu_skip;
        // RULE_05 skip over fetched word
        if (alu_skip)
        begin
          pc_ff <= pc_adv(pc_ff, 1'b1);
          cycles_ff <= `MIX_CYC_TWO;
        end
        else
        begin
          pc_ff <= pc_adv(pc_ff, 1'b0);
          cycles_ff <= `MIX_CYC_ONE;
        end
      end
      else if (state_ff == S_TBL)
      begin
        // RULE_13 RULE_14 high byte latch
        table_high_latch_ff <= rom_rdata[15:8];
        skip_ff <= 1'b0;
        pc_ff <= pc_adv(pc_ff, 1'b0);
        cycles_ff <= `MIX_CYC_TWO;
      end
      else if (wr_ok)
      begin
        if (is_reg(paddr, `MIX_OFF_ACC))
          acc_ff <= pwdata[7:0];
        if (is_reg(paddr, `MIX_OFF_STATUS))
          flags_ff <= pwdata[3:0];
        if (is_reg(paddr, `MIX_OFF_PC))
          pc_ff <= pwdata[11:0];
      end
    end
  end

  // ==========================================================
  // Software-owned pointers
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      table_pointer_ff <= `MIX_RST_BYTE;
      maddr_ff <= `MIX_RST_BYTE;
    end
    else if (wr_ok)
    begin
      if (is_reg(paddr, `MIX_OFF_TPTR))
        table_pointer_ff <= pwdata[7:0];
      if (is_reg(paddr, `MIX_OFF_MADDR))
        maddr_ff <= pwdata[7:0];
    end
  end

  // ==========================================================
  // Read mux
  always @*
  begin
    nxt_prdata = 32'h00000000;
    nxt_err = !mapped(paddr) || (pwrite && busy_ff);
    if (!pwrite)
    begin
      case (paddr)
        `MIX_OFF_INSTR:
          nxt_prdata = {8'h00, instr_ff};
        `MIX_OFF_ACC:
          nxt_prdata = {24'h000000, acc_ff};
        `MIX_OFF_STATUS:
          nxt_prdata = status_word(flags_ff, busy_ff, skip_ff);
        `MIX_OFF_PC:
          nxt_prdata = {20'h00000, pc_ff};
        `MIX_OFF_TPTR:
          nxt_prdata = {24'h000000, table_pointer_ff};
        `MIX_OFF_THI:
          nxt_prdata = {24'h000000, table_high_latch_ff};
        `MIX_OFF_MADDR:
          nxt_prdata = {24'h000000, maddr_ff};
        // Reads memory only while idle, else the core owns the port
        `MIX_OFF_MDATA:
          nxt_prdata = busy_ff ? 32'h00000000 : {24'h000000, mem_rdata};
        `MIX_OFF_CYCLES:
          nxt_prdata = {30'h00000000, cycles_ff};
        default:
          nxt_prdata = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end
    else
    begin
      pready_ff <= acc_phase;
      pslverr_ff <= acc_phase && nxt_err;
      if (acc_phase)
        prdata_ff <= nxt_prdata;
      else
        prdata_ff <= 32'h00000000;
    end
  end
endmodule // mix_core

//--- tb/mix_core_props.sv
`timescale 1ns/1ps
`include "mix_defs.vh"
// ========================================
// Port checker for the instruction core
module mix_core_props
(
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata_ff,
  input wire pready_ff,
  input wire pslverr_ff,
  // ROM and status
  input wire [11:0] rom_addr_ff,
  input wire rom_rd_ff,
  input wire [15:0] rom_rdata,
  input wire busy_ff
);
  logic [4:0] op_ff;
  logic [4:0] nxt_op;
  wire take = psel && penable && !pready_ff;
  wire launch = take && pwrite && paddr == `MIX_OFF_INSTR && !busy_ff;
  wire tbl = op_ff == `MIX_OP_TRDC || op_ff == `MIX_OP_TRDL;
  // Ops that can never skip nor read the ROM
  wire plain = op_ff inside {`MIX_OP_SET, `MIX_OP_SETB, `MIX_OP_SUB, `MIX_OP_SUBINTO,
    `MIX_OP_SUBI, `MIX_OP_SWAP, `MIX_OP_SWAPACC, `MIX_OP_XOR, `MIX_OP_XORINTO, `MIX_OP_XORI};
  assign nxt_op = launch ? pwdata[4:0] : op_ff;
  always @(posedge clk)
    if (!reset_n)
      op_ff <= 5'h00;
    else
      op_ff <= nxt_op;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_ready_pulse: assert property (take |=> pready_ff ##1 !pready_ff)
    else $error("pready not a single pulse after access");
  a_err_ready: assert property (pslverr_ff |-> pready_ff)
    else $error("pslverr without pready");
  a_rdata_quiet: assert property (!pready_ff |-> prdata_ff == 32'h0)
    else $error("read data outside answer cycle");
  a_unmapped_err: assert property (take && paddr > `MIX_OFF_CYCLES |=> pslverr_ff)
    else $error("unmapped access not refused");
  a_instr_launch: assert property (launch |-> ##[1:2] busy_ff)
    else $error("instruction write did not start");
  a_busy_bound: assert property ($rose(busy_ff) |-> ##[1:2] !busy_ff)
    else $error("instruction longer than two cycles");
  a_plain_one: assert property ($rose(busy_ff) && plain |=> !busy_ff)
    else $error("non-skip op took more than one cycle");
  a_table_seq: assert property ($rose(busy_ff) && tbl |-> !rom_rd_ff ##1
    (rom_rd_ff && busy_ff) ##1 (!busy_ff && !rom_rd_ff))
    else $error("table read sequence wrong");
  a_rom_owner: assert property (rom_rd_ff |-> busy_ff && tbl)
    else $error("ROM read outside table read");
  a_last_page: assert property (rom_rd_ff && op_ff == `MIX_OP_TRDL |->
    rom_addr_ff[11:8] == `MIX_LAST_PAGE)
    else $error("last page table read wrong page");
  c_table: cover property ($rose(busy_ff) && tbl);
  c_skip: cover property ($rose(busy_ff) && !tbl ##1 busy_ff);
  c_error: cover property (pslverr_ff);
endmodule // mix_core_props

bind mix_core mix_core_props mix_core_props_i (.clk, .reset_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata_ff, .pready_ff, .pslverr_ff, .rom_addr_ff, .rom_rd_ff,
  .rom_rdata, .busy_ff);

//--- tb/mix_rom_model.sv
`timescale 1ns/1ps
// ========================================
// Program ROM seen by the core
module mix_rom_model
(
  // Clock
  input wire clk,
  // Read request
  input wire [11:0] rom_addr_ff,
  input wire rom_rd_ff,
  output wire [15:0] rom_rdata
);
  logic [7:0] noise_ff = 8'h5A;
  always @(posedge clk)
    noise_ff <= noise_ff + 8'h3B;
  // word on request
  // Junk outside the read pulse so a late capture is caught
  assign rom_rdata = rom_rd_ff ? {rom_addr_ff[3:0], rom_addr_ff[11:8],
    rom_addr_ff[7:0] ^ 8'hA5} : {noise_ff, ~noise_ff};
endmodule // mix_rom_model

//--- tb/mix_core_tb.sv
`timescale 1ns/1ps
`include "mix_defs.vh"
// ========================================
// Self-checking bench for the instruction core
module mix_core_tb;
  logic clk, reset_n, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, r;
  wire [31:0] prdata_ff;
  wire pready_ff, pslverr_ff, rom_rd_ff, busy_ff;
  wire [11:0] rom_addr_ff;
  wire [15:0] rom_rdata;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] e_acc, e_mem, e_thi;
  logic [3:0] e_fl;
  logic [11:0] e_pc;
  logic e_skip, e_tbl, e;

  mix_core mix_core_i (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata_ff, .pready_ff, .pslverr_ff, .rom_addr_ff, .rom_rd_ff, .rom_rdata, .busy_ff);
  mix_rom_model mix_rom_model_i (.clk, .rom_addr_ff, .rom_rd_ff, .rom_rdata);

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready_ff !== 1'b1 && n < 20);
    r = prdata_ff;
    e = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
      chk("pready", 32'h1, 32'h0);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, x, r);
  endtask

  function automatic logic [15:0] romw(input logic [11:0] a);
    return {a[3:0], a[11:8], a[7:0] ^ 8'hA5};
  endfunction

  // Returns {OV, Z, AC, C, difference}
  function automatic logic [11:0] subf(input logic [7:0] a, input logic [7:0] x);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, ~x} + 9'h001;
    h = {1'b0, a[3:0]} + {1'b0, ~x[3:0]} + 5'h01;
    return {(a[7] ^ x[7]) & (a[7] ^ s[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction

  function automatic void predict(input logic [4:0] op, input logic [2:0] b,
    input logic [7:0] a, m, imm, tp, input logic [3:0] f, input logic [11:0] pc);
    logic [15:0] w;
    e_acc = a;
    e_mem = m;
    e_fl = f;
    e_skip = 1'b0;
    e_tbl = 1'b0;
    w = romw({pc[11:8], tp});
    case (op)
      `MIX_OP_SET: e_mem = 8'hFF;
      `MIX_OP_SETB: e_mem = m | (8'h01 << b);
      `MIX_OP_INCS: {e_skip, e_mem} = {m == 8'hFF, m + 8'h01};
      `MIX_OP_INCAS: {e_skip, e_acc} = {m == 8'hFF, m + 8'h01};
      `MIX_OP_SBIT1: e_skip = m[b];
      `MIX_OP_SBIT0: e_skip = !m[b];
      `MIX_OP_SUB: {e_fl, e_acc} = subf(a, m);
      `MIX_OP_SUBINTO: {e_fl, e_mem} = subf(a, m);
      `MIX_OP_SUBI: {e_fl, e_acc} = subf(a, imm);
      `MIX_OP_SWAP: e_mem = {m[3:0], m[7:4]};
      `MIX_OP_SWAPACC: e_acc = {m[3:0], m[7:4]};
      `MIX_OP_SKZ: e_skip = m == 8'h00;
      `MIX_OP_CPSKZ: {e_skip, e_acc} = {m == 8'h00, m};
      `MIX_OP_TRDC: e_tbl = 1'b1;
      `MIX_OP_TRDL: {e_tbl, w} = {1'b1, romw({`MIX_LAST_PAGE, tp})};
      `MIX_OP_XOR: {e_fl[2], e_acc} = {(a ^ m) == 8'h00, a ^ m};
      `MIX_OP_XORINTO: {e_fl[2], e_mem} = {(a ^ m) == 8'h00, a ^ m};
      `MIX_OP_XORI: {e_fl[2], e_acc} = {(a ^ imm) == 8'h00, a ^ imm};
      default: e_acc = a;
    endcase
    if (e_tbl)
      {e_thi, e_mem} = w;
    e_pc = pc + (e_skip ? 12'h002 : 12'h001);
  endfunction

  // Rounds: byte FFh, byte 00h, then random; odd rounds make acc equal the byte
  task automatic run_op(input int i);
    logic [7:0] a, m, imm, adr, tp;
    logic [3:0] f;
    logic [11:0] pc;
    int n;
    m = (i / 20 == 0) ? 8'hFF : (i / 20 == 1) ? 8'h00 : 8'($urandom);
    a = ((i / 20) % 2 == 1) ? m : 8'($urandom);
    imm = (i / 20 == 2) ? a : 8'($urandom);
    adr = 8'($urandom);
    tp = 8'($urandom);
    f = 4'($urandom);
    pc = 12'($urandom);
    n = 0;
    apb(1'b1, `MIX_OFF_MADDR, {24'h0, adr});
    apb(1'b1, `MIX_OFF_MDATA, {24'h0, m});
    apb(1'b1, `MIX_OFF_ACC, {24'h0, a});
    apb(1'b1, `MIX_OFF_STATUS, {28'h0, f});
    apb(1'b1, `MIX_OFF_PC, {20'h0, pc});
    apb(1'b1, `MIX_OFF_TPTR, {24'h0, tp});
    predict(5'(i % 20), 3'(i / 3), a, m, imm, tp, f, pc);
    apb(1'b1, `MIX_OFF_INSTR, {8'h00, imm, adr, 3'(i / 3), 5'(i % 20)});
    do
    begin
      @(posedge clk);
      n++;
    end
    while (busy_ff !== 1'b0 && n < 10);
    if (n == 10)
      chk("busy", 32'h0, 32'h1);
    rdc("acc", `MIX_OFF_ACC, {24'h0, e_acc});
    rdc("status", `MIX_OFF_STATUS, {22'h0, e_skip, 5'h00, e_fl});
    rdc("mem", `MIX_OFF_MDATA, {24'h0, e_mem});
    rdc("pc", `MIX_OFF_PC, {20'h0, e_pc});
    rdc("cycles", `MIX_OFF_CYCLES, (e_skip || e_tbl) ? 32'h2 : 32'h1);
    rdc("latch", `MIX_OFF_THI, {24'h0, e_thi});
  endtask

  initial
  begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    e_thi = 8'h00;
    void'($urandom(32'h4B261154));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    // Data memory is not cleared by reset, so its window is left out
    for (int k = 0; k <= 32; k += 4)
      if (8'(k) != `MIX_OFF_MDATA)
        rdc("reset value", 8'(k), 32'h0);
    apb(1'b1, `MIX_OFF_STATUS, 32'hFFFFFFFF);
    rdc("status bits", `MIX_OFF_STATUS, 32'h0000000F);
    $display("reset and register test done");
    for (int i = 0; i < 100; i++)
      run_op(i);
    $display("instruction test done");
    apb(1'b1, 8'h24, 32'hFFFFFFFF);
    chk("write refused", 32'h1, {31'h0, e});
    rdc("unmapped data", 8'h40, 32'h0);
    chk("read refused", 32'h1, {31'h0, e});
    $display("unmapped test done");
    wrap_up();
  end
endmodule // mix_core_tb
